// ===== rtl/tmpm_top.sv
// Transmit multifunction port mux: four ports, each steered by its own 4-bit function code.
// Overview of operation
// - Code 0010 takes signaling data input
// - Gating option samples only under own marker
// - Sampling point chosen by 3-bit select
// - External clock may reference the internal oscillator
// - Code 0100 pulses at multiframe start
// - Code 0101 marks selected time slots
// - Robbed-bit mode marks robbed bit, sixth frame
// - E1 code 0110 marks enabled spare bits
// - T1 data-link marker only in extended superframe
// - Code 0111 outputs transmit line clock
// - Code 1000 input ORed into line tristate
// - Code 1001 level readable in status
// - Codes 1010/1011 drive fixed high/low
// - Ports are inputs after reset, direction automatic
// - Edge select picks latching clock edge
`include "tmpm_params.svh"
module tmpm_top (
   input wire logic clk,                               // 20 MHz system clock
   input wire logic rstn,                              // asynchronous reset, active low
   input wire logic [`TMPM_AW-1:0] regAddr,            // register address
   input wire logic [`TMPM_DW-1:0] regWrData,          // register write data
   input wire logic regWr,                             // write strobe
   input wire logic regRd,                             // read strobe
   output logic [`TMPM_DW-1:0] regRdData,              // read data, cycle after strobe
   input wire logic txSysClk,                          // transmit system clock level
   input wire logic [`TMPM_NPORT-1:0] txMultiportIn,   // port pin levels
   output logic [`TMPM_NPORT-1:0] txMultiportOut,      // port pin drive values
   output logic [`TMPM_NPORT-1:0] txMultiportOe,       // port pin drive enables
   output logic [`TMPM_DW-1:0] sigData,                // assembled signaling byte
   output logic sigValid,                              // signaling byte available
   input wire logic sigReady,                          // core takes the byte
   output logic lineTristate,                          // transmit line outputs in tristate
   output logic extTxClk,                              // external transmit clock level
   output logic oscRefClk                              // oscillator reference clock level
);
   import tmpm_pkg::*;

   logic rstMeta_q;
   logic rstSyncN_q;
   logic [3:0] cfg_q [`TMPM_NPORT];
   tmpm_mode_t mode_q;
   logic [5:0] sample_q;
   logic [4:0] spareEn_q;
   logic [7:0] slot_q [4];
   logic ovf_q;
   logic [7:0] shift_q;
   logic [2:0] shiftCnt_q;
   logic pend_q;
   logic [7:0] pendData_q;
   logic bufInReady;
   tmpm_timing_t tim;
   logic [`TMPM_NPORT-1:0] isSig;
   logic [`TMPM_NPORT-1:0] isClk;
   logic [`TMPM_NPORT-1:0] isTri;
   logic [`TMPM_NPORT-1:0] isLevel;
   logic [31:0] slotSel;
   logic [7:0] chanBit;
   logic mfNow;
   logic markNow;
   logic dlNow;
   logic sigBit;
   logic takeSig;
   logic byteDone;
   logic statusRd;
   logic [`TMPM_DW-1:0] rdData_d;

   // The reset is released through two flops so that every flop leaves reset on the same edge.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta_q <= 1'b0;
         rstSyncN_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSyncN_q <= rstMeta_q;
      end
   end

   // Register writes.
   always_ff @(posedge clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         for (int i = 0; i < `TMPM_NPORT; i++) begin
            cfg_q[i] <= `TMPM_FUNC_RESET;
         end
         for (int i = 0; i < 4; i++) begin
            slot_q[i] <= `TMPM_SLOT_RESET;
         end
         mode_q <= `TMPM_MODE_RESET;
         sample_q <= `TMPM_SAMPLE_RESET;
         spareEn_q <= `TMPM_SPARE_RESET;
      end else if (regWr) begin
         for (int i = 0; i < `TMPM_NPORT; i++) begin
            if (regAddr == `TMPM_OFS_PORTCFG + 4'(i)) begin
               cfg_q[i] <= regWrData[3:0];
            end
         end
         for (int i = 0; i < 4; i++) begin
            if (regAddr == `TMPM_OFS_SLOT + 4'(i)) begin
               slot_q[i] <= regWrData;
            end
         end
         if (regAddr == `TMPM_OFS_MODE) begin
            mode_q <= tmpm_mode_t'(regWrData[6:0]);
         end
         if (regAddr == `TMPM_OFS_SAMPLE) begin
            sample_q <= regWrData[5:0];
         end
         if (regAddr == `TMPM_OFS_SPARE) begin
            spareEn_q <= regWrData[4:0];
         end
      end
   end

   tmpm_timing u_timing (
      .clk(clk),
      .rstN(rstSyncN_q),
      .txSysClk(txSysClk),
      .mode(mode_q),
      .ratio(sample_q[`TMPM_RATIO_MSB:`TMPM_RATIO_LSB]),
      .samplePt(sample_q[`TMPM_SAMPLE_PT_MSB:0]),
      .tim(tim)
   );

   // Marker timing for the bit now on the transmit data stream.
   always_comb begin
      slotSel = {slot_q[3], slot_q[2], slot_q[1], slot_q[0]};
      // In T1 bit 0 is the framing bit, so channel bits start one later.
      chanBit = mode_q.t1Mode ? tim.bitIdx - 8'h01 : tim.bitIdx;
      mfNow = (tim.frameIdx == 5'h00) && (tim.bitIdx == 8'h00);
      if (mode_q.t1Mode && mode_q.robbed) begin
         markNow = tim.robbedFrame && (tim.bitIdx != 8'h00)
                   && (chanBit[2:0] == `TMPM_SLOT_BIT_LAST);
      end else if (mode_q.t1Mode && tim.bitIdx == 8'h00) begin
         markNow = 1'b0;
      end else begin
         markNow = slotSel[chanBit[7:3]];
      end
      if (mode_q.t1Mode) begin
         dlNow = mode_q.extended_superframe && (tim.bitIdx == 8'h00) && !tim.frameIdx[0];
      end else begin
         dlNow = tim.frameIdx[0] && (tim.bitIdx[7:3] == 5'h00) && (tim.bitIdx[2:0] >= `TMPM_SPARE_FIRST)
                 && spareEn_q[3'(tim.bitIdx[2:0] - `TMPM_SPARE_FIRST)];
      end
   end

   // Per-port function decode and registered pin drive.
   for (genvar p = 0; p < `TMPM_NPORT; p++) begin : g_port
      tmpm_func_t fn;
      assign fn = tmpm_func_t'(cfg_q[p]);
      assign isSig[p] = (fn == FN_SIG_IN);
      assign isClk[p] = (fn == FN_EXTCLK_IN);
      assign isTri[p] = (fn == FN_TRISTATE_IN);
      assign isLevel[p] = (fn == FN_LEVEL_IN);

      always_ff @(posedge clk or negedge rstSyncN_q) begin
         if (!rstSyncN_q) begin
            txMultiportOut[p] <= 1'b0;
            txMultiportOe[p] <= 1'b0;
         end else begin
            case (fn)
               FN_MF_BEGIN: begin
                  txMultiportOut[p] <= mfNow;
                  txMultiportOe[p] <= 1'b1;
               end
               FN_SIG_MARK: begin
                  txMultiportOut[p] <= markNow;
                  txMultiportOe[p] <= 1'b1;
               end
               FN_DL_MARK: begin
                  txMultiportOut[p] <= dlNow;
                  txMultiportOe[p] <= 1'b1;
               end
               FN_LINE_CLK: begin
                  txMultiportOut[p] <= tim.lineClk;
                  txMultiportOe[p] <= 1'b1;
               end
               FN_DRIVE_HIGH: begin
                  txMultiportOut[p] <= 1'b1;
                  txMultiportOe[p] <= 1'b1;
               end
               FN_DRIVE_LOW: begin
                  txMultiportOut[p] <= 1'b0;
                  txMultiportOe[p] <= 1'b1;
               end
               default: begin
                  // Input functions and reserved codes leave the pin undriven.
                  txMultiportOut[p] <= 1'b0;
                  txMultiportOe[p] <= 1'b0;
               end
            endcase
         end
      end
   end

   // Software is expected to select each input function on one port only; if it does not,
   // the signaling, clock and tristate levels are simply ORed.
   assign sigBit = |(txMultiportIn & isSig);
   assign takeSig = tim.sampleTick && (|isSig) && (!mode_q.gating || markNow);
   assign byteDone = takeSig && (shiftCnt_q == `TMPM_SLOT_BIT_LAST);

   // Serial signaling bits are packed MSB first into bytes.
   always_ff @(posedge clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         shift_q <= 8'h00;
         shiftCnt_q <= 3'h0;
      end else if (takeSig) begin
         shift_q <= {shift_q[6:0], sigBit};
         shiftCnt_q <= shiftCnt_q + 3'h1;
      end
   end

   // A finished byte waits here while the buffer is full; the line cannot be stalled,
   // so a second byte arriving meanwhile is dropped and flagged.
   always_ff @(posedge clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         pend_q <= 1'b0;
         pendData_q <= 8'h00;
         ovf_q <= 1'b0;
      end else begin
         if (byteDone && (!pend_q || bufInReady)) begin
            pend_q <= 1'b1;
            pendData_q <= {shift_q[6:0], sigBit};
         end else if (bufInReady) begin
            pend_q <= 1'b0;
         end
         if (byteDone && pend_q && !bufInReady) begin
            ovf_q <= 1'b1;
         end else if (statusRd) begin
            ovf_q <= 1'b0;
         end
      end
   end

   tmpm_buf #(
      .W(`TMPM_DW)
   ) u_buf (
      .clk(clk),
      .rstN(rstSyncN_q),
      .inData(pendData_q),
      .inValid(pend_q),
      .inReady(bufInReady),
      .outData(sigData),
      .outValid(sigValid),
      .outReady(sigReady)
   );

   // Line tristate, external clock pass-through and oscillator reference.
   always_ff @(posedge clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         lineTristate <= 1'b0;
         extTxClk <= 1'b0;
         oscRefClk <= 1'b0;
      end else begin
         lineTristate <= mode_q.tristateReg || (|(txMultiportIn & isTri));
         extTxClk <= |(txMultiportIn & isClk);
         oscRefClk <= mode_q.oscRefEn && (|(txMultiportIn & isClk));
      end
   end

   // Register reads; data stand only in the cycle after the strobe.
   assign statusRd = regRd && (regAddr == `TMPM_OFS_STATUS);
   always_comb begin
      rdData_d = 8'h00;
      for (int i = 0; i < `TMPM_NPORT; i++) begin
         if (regAddr == `TMPM_OFS_PORTCFG + 4'(i)) begin
            rdData_d = {4'h0, cfg_q[i]};
         end
      end
      for (int i = 0; i < 4; i++) begin
         if (regAddr == `TMPM_OFS_SLOT + 4'(i)) begin
            rdData_d = slot_q[i];
         end
      end
      if (regAddr == `TMPM_OFS_MODE) begin
         rdData_d = {1'b0, mode_q};
      end
      if (regAddr == `TMPM_OFS_SAMPLE) begin
         rdData_d = {2'h0, sample_q};
      end
      if (regAddr == `TMPM_OFS_SPARE) begin
         rdData_d = {3'h0, spareEn_q};
      end
      if (regAddr == `TMPM_OFS_STATUS) begin
         rdData_d[3:0] = txMultiportIn & isLevel;
         rdData_d[`TMPM_STAT_TRI_BIT] = lineTristate;
         rdData_d[`TMPM_STAT_OVF_BIT] = ovf_q;
      end
   end

   always_ff @(posedge clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
         regRdData <= 8'h00;
      end else begin
         regRdData <= regRd ? rdData_d : 8'h00;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSyncN_q);

   property p_mf_begin;
      (cfg_q[1] == 4'h4) && mfNow |=> txMultiportOut[1] && txMultiportOe[1];
   endproperty
   a_mf_begin: assert property (p_mf_begin) else $error("multiframe begin not driven");

   property p_mark_gap;
      (cfg_q[3] == 4'h5) && !markNow |=> !txMultiportOut[3];
   endproperty
   a_mark_gap: assert property (p_mark_gap) else $error("signaling marker outside slot");

   property p_robbed;
      (cfg_q[3] == 4'h5) && mode_q.t1Mode && mode_q.robbed && !tim.robbedFrame |=> !txMultiportOut[3];
   endproperty
   a_robbed: assert property (p_robbed) else $error("robbed bit marked off sixth frame");

   property p_dl_esf;
      (cfg_q[3] == 4'h6) && mode_q.t1Mode && !mode_q.extended_superframe |=> !txMultiportOut[3];
   endproperty
   a_dl_esf: assert property (p_dl_esf) else $error("data-link marker outside superframe mode");

   property p_fixed;
      (cfg_q[3] == 4'ha) ##1 (cfg_q[3] == 4'ha) |-> txMultiportOut[3] && txMultiportOe[3];
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed high level not driven");

   property p_reserved;
      (cfg_q[3] > 4'hb) |=> !txMultiportOe[3];
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved code drives port");

   property p_reset_in;
      $rose(rstSyncN_q) |-> (txMultiportOe == 4'h0) ##1 (txMultiportOe == 4'h0);
   endproperty
   a_reset_in: assert property (@(posedge clk) p_reset_in) else $error("port driven after reset");

   property p_tristate;
      (|(txMultiportIn & isTri)) || mode_q.tristateReg |=> lineTristate;
   endproperty
   a_tristate: assert property (p_tristate) else $error("tristate request lost");

   property p_gate;
      tim.sampleTick && mode_q.gating && !markNow |=> $stable(shift_q) && $stable(shiftCnt_q);
   endproperty
   a_gate: assert property (p_gate) else $error("signaling sampled outside marker");

   property p_level;
      statusRd && isLevel[0] |=> regRdData[0] == $past(txMultiportIn[0]);
   endproperty
   a_level: assert property (p_level) else $error("input level not reported");

   c_byte: cover property (sigValid && sigReady);
   c_stall: cover property (pend_q && !bufInReady);
   c_mf: cover property (mfNow && (cfg_q[1] == 4'h4));
   c_ovf: cover property ($rose(ovf_q));
endmodule

// ===== rtl/tmpm_params.svh
// Offsets, field positions, reset values and frame counts for the transmit multifunction port mux.
`ifndef TMPM_PARAMS_SVH
`define TMPM_PARAMS_SVH
`define TMPM_AW 4
`define TMPM_DW 8
`define TMPM_NPORT 4
`define TMPM_OFS_PORTCFG 4'h0
`define TMPM_OFS_MODE 4'h4
`define TMPM_OFS_SAMPLE 4'h5
`define TMPM_OFS_SPARE 4'h6
`define TMPM_OFS_SLOT 4'h8
`define TMPM_OFS_STATUS 4'hc
`define TMPM_FUNC_RESET 4'h0
`define TMPM_MODE_RESET 7'h00
`define TMPM_SAMPLE_RESET 6'h00
`define TMPM_SPARE_RESET 5'h00
`define TMPM_SLOT_RESET 8'h00
`define TMPM_SAMPLE_PT_MSB 2
`define TMPM_RATIO_LSB 4
`define TMPM_RATIO_MSB 5
`define TMPM_E1_BIT_LAST 8'hff
`define TMPM_T1_BIT_LAST 8'hc0
`define TMPM_E1_MF_LAST 5'h0f
`define TMPM_T1_ESF_MF_LAST 5'h17
`define TMPM_T1_SF_MF_LAST 5'h0b
`define TMPM_ROBBED_LAST 3'h5
`define TMPM_SPARE_FIRST 3'h3
`define TMPM_SLOT_BIT_LAST 3'h7
`define TMPM_STAT_TRI_BIT 4
`define TMPM_STAT_OVF_BIT 5
`endif

// ===== rtl/tmpm_pkg.sv
// Types shared by the transmit multifunction port mux modules.
package tmpm_pkg;
   typedef enum logic [3:0] {
      FN_SYNC_IN = 4'h0,
      FN_MFSYNC_IN = 4'h1,
      FN_SIG_IN = 4'h2,
      FN_EXTCLK_IN = 4'h3,
      FN_MF_BEGIN = 4'h4,
      FN_SIG_MARK = 4'h5,
      FN_DL_MARK = 4'h6,
      FN_LINE_CLK = 4'h7,
      FN_TRISTATE_IN = 4'h8,
      FN_LEVEL_IN = 4'h9,
      FN_DRIVE_HIGH = 4'ha,
      FN_DRIVE_LOW = 4'hb
   } tmpm_func_t;

   typedef struct packed {
      logic oscRefEn;
      logic tristateReg;
      logic gating;
      logic edgeSel;
      logic extended_superframe;
      logic robbed;
      logic t1Mode;
   } tmpm_mode_t;

   typedef struct packed {
      logic bitTick;
      logic sampleTick;
      logic lineClk;
      logic robbedFrame;
      logic [7:0] bitIdx;
      logic [4:0] frameIdx;
   } tmpm_timing_t;
endpackage

// ===== rtl/tmpm_buf.sv
// Two-entry skid buffer carrying assembled signaling bytes to the framer core.
module tmpm_buf #(
   parameter int W = 8
) (
   input wire logic clk,                // system clock
   input wire logic rstN,               // synchronised reset, active low
   input wire logic [W-1:0] inData,     // word from the assembler
   input wire logic inValid,            // word offered
   output logic inReady,                // buffer can take a word
   output logic [W-1:0] outData,        // word to the core
   output logic outValid,               // word available
   input wire logic outReady            // core takes the word
);
   import tmpm_pkg::*;
   logic [W-1:0] skid_q;
   logic skidValid_q;

   // Second entry only fills when the core stalls, so inReady is a plain flop.
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         outData <= '0;
         outValid <= 1'b0;
         skid_q <= '0;
         skidValid_q <= 1'b0;
      end else begin
         if (!outValid || outReady) begin
            if (skidValid_q) begin
               outData <= skid_q;
               outValid <= 1'b1;
               skidValid_q <= 1'b0;
            end else begin
               outData <= inData;
               outValid <= inValid;
            end
         end else if (inValid && !skidValid_q) begin
            skid_q <= inData;
            skidValid_q <= 1'b1;
         end
      end
   end

   assign inReady = !skidValid_q;
endmodule

// ===== rtl/tmpm_timing.sv
// Bit, frame and multiframe counters paced by the selected edge of the transmit system clock.
module tmpm_timing (
   input wire logic clk,                       // system clock
   input wire logic rstN,                      // synchronised reset, active low
   input wire logic txSysClk,                  // transmit system clock level
   input wire tmpm_pkg::tmpm_mode_t mode,      // mode bits
   input wire logic [1:0] ratio,               // log2 of transmit system clock periods per line bit
   input wire logic [2:0] samplePt,            // sampling point within a bit
   output tmpm_pkg::tmpm_timing_t tim          // registered timing state
);
   import tmpm_pkg::*;
   logic sysPrev_q;
   logic [2:0] sub_q;
   logic [2:0] robbed_q;
   logic [2:0] ratioLast;
   logic edgeNow;
   logic [7:0] bitLast;
   logic [4:0] mfLast;

   always_comb begin
      ratioLast = 3'h0;
      case (ratio)
         2'h1: ratioLast = 3'h1;
         2'h2: ratioLast = 3'h3;
         2'h3: ratioLast = 3'h7;
         default: ratioLast = 3'h0;
      endcase
      edgeNow = mode.edgeSel ? (sysPrev_q && !txSysClk) : (!sysPrev_q && txSysClk);
      bitLast = mode.t1Mode ? `TMPM_T1_BIT_LAST : `TMPM_E1_BIT_LAST;
      mfLast = !mode.t1Mode ? `TMPM_E1_MF_LAST : (mode.extended_superframe ? `TMPM_T1_ESF_MF_LAST : `TMPM_T1_SF_MF_LAST);
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         sysPrev_q <= 1'b0;
         sub_q <= 3'h0;
         robbed_q <= 3'h0;
         tim <= '0;
      end else begin
         sysPrev_q <= txSysClk;
         // Above the basic rate one of several system edges per bit is the sampling point.
         tim.sampleTick <= edgeNow && (sub_q == (samplePt & ratioLast));
         tim.bitTick <= edgeNow && (sub_q == ratioLast);
         tim.lineClk <= (ratio == 2'h0) ? txSysClk : (sub_q <= (ratioLast >> 1));
         tim.robbedFrame <= (robbed_q == `TMPM_ROBBED_LAST);
         if (edgeNow) begin
            sub_q <= (sub_q == ratioLast) ? 3'h0 : sub_q + 3'h1;
            if (sub_q == ratioLast) begin
               if (tim.bitIdx >= bitLast) begin
                  tim.bitIdx <= 8'h00;
                  tim.frameIdx <= (tim.frameIdx >= mfLast) ? 5'h00 : tim.frameIdx + 5'h01;
                  robbed_q <= (robbed_q == `TMPM_ROBBED_LAST) ? 3'h0 : robbed_q + 3'h1;
               end else begin
                  tim.bitIdx <= tim.bitIdx + 8'h01;
               end
            end
         end
      end
   end
endmodule

// ===== verif/tmpm_highway_model.sv
// Behavioural system highway: transmit system clock and a signaling byte stream.
module tmpm_highway_model (
   input wire logic clk,    // system clock
   input wire logic run,    // highway running
   output logic txSysClk,   // transmit system clock
   output logic sigBit,     // signaling data on the pin
   output logic sigEn       // pin driven by the highway
);
   timeunit 1ns;
   timeprecision 1ns;
   int phase = 0;
   int bitNo = 0;
   logic [7:0] cur;
   // The clock stands low until run, so the mux sees no edge before it is configured.
   always @(posedge clk) begin
      if (run) begin
         phase <= (phase == 11) ? 0 : phase + 1;
         if (phase == 11) begin
            bitNo <= bitNo + 1;
         end
      end
   end
   assign txSysClk = run && phase >= 6;
   // Data change at the falling edge so they are stable around the latching rising edge.
   assign cur = 8'h1d + 8'h37 * 8'(bitNo / 8);
   assign sigBit = cur[7 - bitNo % 8];
   assign sigEn = run;
endmodule

// ===== verif/tmpm_tb_top.sv
// Self-checking bench for the transmit multifunction port mux.
module tmpm_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, regWr, regRd, sigReady, run, sigValid, lineTristate, extTxClk, oscRefClk;
   logic [3:0] regAddr, pin, pOut, pOe, tbDrv, tbEn, p;
   logic [7:0] regWrData, regRdData, sigData, m;
   logic txSysClk, mBit, mEn, prevMf, prevLc, prev3;
   int miscompares = 0, comparisons = 0, cyc = 0, lineRises = 0, lastW = 0, n0, r3, w3;
   int rT[$];
   int rC[$];
   int sel[4] = '{0, 1, 2, 5};
   logic [7:0] got[$];
   tmpm_top uut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
      .regRd(regRd), .regRdData(regRdData), .txSysClk(txSysClk), .txMultiportIn(pin),
      .txMultiportOut(pOut), .txMultiportOe(pOe), .sigData(sigData), .sigValid(sigValid),
      .sigReady(sigReady), .lineTristate(lineTristate), .extTxClk(extTxClk), .oscRefClk(oscRefClk));
   tmpm_highway_model hw (.clk(clk), .run(run), .txSysClk(txSysClk), .sigBit(mBit), .sigEn(mEn));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Undriven pins float high through the pull-up.
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin[i] = pOe[i] ? pOut[i] : (i == 0 && mEn) ? mBit : tbEn[i] ? tbDrv[i] : 1'b1;
      end
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      prevMf <= pOut[1];
      prevLc <= pOut[2];
      if (pOut[2] && !prevLc) lineRises <= lineRises + 1;
      if (pOut[1] && !prevMf) begin
         rT.push_back(cyc);
         rC.push_back(lineRises);
      end
      if (!pOut[1] && prevMf) lastW <= cyc - rT[$];
      prev3 <= pOut[3];
      if (pOut[3] && !prev3) r3 <= cyc;
      if (!pOut[3] && prev3) w3 <= cyc - r3;
      if (sigValid === 1'b1 && sigReady) got.push_back(sigData);
      if (cyc == 90000) begin
         miscompares++;
         print_verdict();
      end
   end
   task automatic check(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      check(regRdData, e);
   endtask
   task print_verdict;
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      rstn = 1'b0;
      {regWr, regRd, sigReady, run} = 4'h0;
      {regAddr, tbDrv, tbEn} = 12'h000;
      regWrData = 8'h00;
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      tick(4);
      check(pOe, 4'h0);
      for (int k = 0; k < 4; k++) rd(k[3:0], 8'h00);
      wr(4'h7, 8'h5a);
      rd(4'h7, 8'h00);
      for (int c = 0; c < 16; c++) begin
         wr(4'h3, c[7:0]);
         tick(4);
         check(pOe[3], c inside {[4:7], 10, 11});
         if (c == 10 || c == 11) check(pOut[3], c == 10);
         rd(4'h3, c[7:0]);
      end
      wr(4'h0, 8'h09);
      wr(4'h1, 8'h03);
      wr(4'h2, 8'h08);
      wr(4'h3, 8'h09);
      tbEn <= 4'hf;
      for (int k = 0; k < 8; k++) begin
         m = (k < 4) ? 8'h00 : 8'h60;
         p = 4'h5 * k[1:0];
         wr(4'h4, m);
         tbDrv <= p;
         tick(5);
         check(pOe, 4'h0);
         check(lineTristate, p[2] | m[5]);
         check(extTxClk, p[1]);
         check(oscRefClk, p[1] & m[6]);
         rd(4'hc, {3'h0, p[2] | m[5], p & 4'h9});
      end
      tbEn <= 4'h0;
      wr(4'h4, 8'h01);
      wr(4'h0, 8'h02);
      wr(4'h1, 8'h04);
      wr(4'h2, 8'h07);
      wr(4'h3, 8'h09);
      tick(4);
      check(pOe, 4'h6);
      rd(4'hc, 8'h08);
      // Receiver stalls: two bytes buffered, one pending, later ones dropped.
      run <= 1'b1;
      tick(530);
      rd(4'hc, 8'h28);
      sigReady <= 1'b1;
      rd(4'hc, 8'h08);
      tick(100);
      check(got.size(), 4);
      for (int j = 0; j < 4; j++) check(got[j], 8'(8'h1d + 8'h37 * sel[j]));
      n0 = rT.size();
      for (int w = 0; w < 60000 && rT.size() < n0 + 2; w++) tick(1);
      tick(20);
      check(rT[n0 + 1] - rT[n0], 2316 * 12);
      check(lastW, 12);
      check(rC[n0 + 1] - rC[n0], 2316);
      // Gating with no marked slot must stop the byte stream.
      wr(4'h4, 8'h11);
      tick(10);
      n0 = got.size();
      tick(600);
      check(got.size(), n0);
      wr(4'h8, 8'h01);
      wr(4'h3, 8'h05);
      tick(2500);
      check(w3, 96);
      wr(4'h4, 8'h13);
      tick(14200);
      check(w3, 12);
      wr(4'h3, 8'h06);
      tick(300);
      check(pOut[3], 1'b0);
      print_verdict();
   end
endmodule
